// *** pkg/pfs_pkg.sv ***
// Purpose: constants for the pin function select block
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: register offsets are byte addresses
`default_nettype none
package pfs_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_SUPPLY = 8'h00;
	localparam logic [7:0] OFF_ISRC0 = 8'h04;
	localparam logic [7:0] OFF_ISRC1 = 8'h08;
	localparam logic [7:0] OFF_PFSEL_BASE = 8'h0C;
	localparam int NUM_PFSEL = 12;
	// ----------------------------------------
	// field layout and reset values
	// ----------------------------------------
	localparam logic [7:0] SUPPLY_MASK = 8'h03;
	localparam logic [7:0] ISRC_MASK = 8'h3F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int SUPPLY_SEL_BIT = 1;
	localparam int SS_LO = 4;
	localparam int CAP_P_LO = 2;
	localparam int CAP_S_LO = 0;
	localparam int SDI_LO = 4;
	localparam int SCK_LO = 2;
	localparam int RX_LO = 0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pfs_pkg
`default_nettype wire

// *** design/pfs_mux.sv ***
// Purpose: pin function select registers and input source routing
// Assumes: pin inputs asynchronous; peripherals on aclk
// Notes: function select bytes are plain storage driving output selects
// Operation
// - supply select upper bit picks io supply
// - supply register bits 7-2 read zero
// - slave select from port A bit 2/3
// - periodic capture from port B bit 2/4
// - standard capture from port E bit 2/3
// - serial data from port B0 or A5
// - serial clock from port B1 or A1
// - receive from port B3 or A1
// - input source bits 7-6 read zero, reset 0
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module pfs_mux (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic port_a_bit1, // port a pin 1
	input wire logic port_a_bit2, // port a pin 2
	input wire logic port_a_bit3, // port a pin 3
	input wire logic port_a_bit5, // port a pin 5
	input wire logic port_b_bit0, // port b pin 0
	input wire logic port_b_bit1, // port b pin 1
	input wire logic port_b_bit2, // port b pin 2
	input wire logic port_b_bit3, // port b pin 3
	input wire logic port_b_bit4, // port b pin 4
	input wire logic port_e_bit2, // port e pin 2
	input wire logic port_e_bit3, // port e pin 3
	output logic slave_select_input, // routed slave select
	output logic periodic_timer_capture_in, // routed periodic capture
	output logic standard_timer_capture_in, // routed standard capture
	output logic serial_data_in, // routed SDI/SDA
	output logic serial_clock_in, // routed SCK/SCL
	output logic serial_rx_in, // routed receive
	output logic port_f_upper_io_supply, // 1: port_f_upper_group on io_supply_pin
	output logic [8*pfs_pkg::NUM_PFSEL-1:0] pin_function_sel // function select bytes
);
	localparam int NPIN = 11;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] supply_source_field_r;
	logic [7:0] input_source_reg_0_r;
	logic [7:0] input_source_reg_1_r;
	logic [7:0] pfsel_r [pfs_pkg::NUM_PFSEL];
	logic [31:0] awaddr_r;
	logic aw_have_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic w_have_r;
	logic [2:0] sy1_r, sy2_r, sy3_r;
	logic [NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
	logic [NPIN-1:0] pin_raw;
	logic do_write;

	// register index decode, -1 when unmapped
	function automatic int reg_index(input logic [31:0] addr);
		int idx;
		idx = -1;
		if (addr[31:8] == 24'h000000 && addr[1:0] == 2'b00) begin
			if (addr[7:0] == pfs_pkg::OFF_SUPPLY)
				idx = 0;
			else if (addr[7:0] == pfs_pkg::OFF_ISRC0)
				idx = 1;
			else if (addr[7:0] == pfs_pkg::OFF_ISRC1)
				idx = 2;
			else if (addr[7:0] >= pfs_pkg::OFF_PFSEL_BASE &&
				int'(addr[7:2]) < int'(pfs_pkg::OFF_PFSEL_BASE[7:2]) + pfs_pkg::NUM_PFSEL)
				idx = 3 + int'(addr[7:2]) - int'(pfs_pkg::OFF_PFSEL_BASE[7:2]);
		end
		return idx;
	endfunction

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

	// hold address and data until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 32'h00000000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pfs_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (reg_index(awaddr_r) < 0) ? pfs_pkg::RESP_SLVERR : pfs_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register storage, low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_source_field_r <= pfs_pkg::REG_RESET;
			input_source_reg_0_r <= pfs_pkg::REG_RESET;
			input_source_reg_1_r <= pfs_pkg::REG_RESET;
			for (int i = 0; i < pfs_pkg::NUM_PFSEL; i++)
				pfsel_r[i] <= pfs_pkg::REG_RESET;
		end else if (do_write && wstrb_r[0]) begin
			case (reg_index(awaddr_r))
				0: supply_source_field_r <= wdata_r[7:0] & pfs_pkg::SUPPLY_MASK;
				1: input_source_reg_0_r <= wdata_r[7:0] & pfs_pkg::ISRC_MASK;
				2: input_source_reg_1_r <= wdata_r[7:0] & pfs_pkg::ISRC_MASK;
				default: begin
					for (int i = 0; i < pfs_pkg::NUM_PFSEL; i++)
						if (reg_index(awaddr_r) == 3 + i)
							pfsel_r[i] <= wdata_r[7:0];
				end
			endcase
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= pfs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= pfs_pkg::RESP_OKAY;
				case (reg_index(s_axi_araddr))
					-1: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= pfs_pkg::RESP_SLVERR;
					end
					0: s_axi_rdata <= {24'h000000, supply_source_field_r};
					1: s_axi_rdata <= {24'h000000, input_source_reg_0_r};
					2: s_axi_rdata <= {24'h000000, input_source_reg_1_r};
					default: begin
						s_axi_rdata <= 32'h00000000;
						for (int i = 0; i < pfs_pkg::NUM_PFSEL; i++)
							if (reg_index(s_axi_araddr) == 3 + i)
								s_axi_rdata <= {24'h000000, pfsel_r[i]};
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pin_raw = {port_e_bit3, port_e_bit2, port_b_bit4, port_b_bit3, port_b_bit2,
		port_b_bit1, port_b_bit0, port_a_bit5, port_a_bit3, port_a_bit2, port_a_bit1};

	// three stages, change taken when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			pin_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < NPIN; i++)
				if (s2_r[i] == s3_r[i])
					pin_r[i] <= s3_r[i];
		end
	end

	// ----------------------------------------
	// input source routing
	// ----------------------------------------
	// registered select outputs, updated one cycle after the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slave_select_input <= 1'b0;
			periodic_timer_capture_in <= 1'b0;
			standard_timer_capture_in <= 1'b0;
			serial_data_in <= 1'b0;
			serial_clock_in <= 1'b0;
			serial_rx_in <= 1'b0;
			port_f_upper_io_supply <= 1'b0;
		end else begin
			// low bit of each field picks the alternate pin
			slave_select_input <= input_source_reg_0_r[pfs_pkg::SS_LO] ?
				pin_r[2] : pin_r[1];
			periodic_timer_capture_in <= input_source_reg_0_r[pfs_pkg::CAP_P_LO] ?
				pin_r[8] : pin_r[6];
			standard_timer_capture_in <= input_source_reg_0_r[pfs_pkg::CAP_S_LO] ?
				pin_r[10] : pin_r[9];
			serial_data_in <= input_source_reg_1_r[pfs_pkg::SDI_LO] ?
				pin_r[3] : pin_r[4];
			// high bit of these fields picks port A bit 1
			serial_clock_in <= input_source_reg_1_r[pfs_pkg::SCK_LO+1] ?
				pin_r[0] : pin_r[5];
			serial_rx_in <= input_source_reg_1_r[pfs_pkg::RX_LO+1] ?
				pin_r[0] : pin_r[7];
			port_f_upper_io_supply <= supply_source_field_r[pfs_pkg::SUPPLY_SEL_BIT];
		end
	end

	// function select bytes straight from registers
	for (genvar g = 0; g < pfs_pkg::NUM_PFSEL; g++) begin : g_pfsel
		assign pin_function_sel[8*g +: 8] = pfsel_r[g];
	end
endmodule // pfs_mux
`default_nettype wire

// *** tb/pfs_mux_props.sv ***
// Purpose: bus answer and reset checks for pfs_mux
// Assumes: sees only pfs_mux ports, one clock
// Notes: bound at the foot of this file
`default_nettype none
module pfs_mux_props (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic slave_select_input, // routed select
	input wire logic port_f_upper_io_supply // supply choice
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ar_ok; // read address taken
	assign ar_ok = s_axi_arvalid && s_axi_arready;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_supply_high_zero: assert property (ar_ok && s_axi_araddr == pfs_pkg::OFF_SUPPLY
		|=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h0) else $error("supply high bits set");
	a_isrc_high_zero: assert property (ar_ok && (s_axi_araddr == pfs_pkg::OFF_ISRC0
		|| s_axi_araddr == pfs_pkg::OFF_ISRC1) |=> s_axi_rdata[31:6] == 26'h0)
		else $error("source high bits set");
	a_unmapped_err: assert property (ar_ok && s_axi_araddr >= 32'h3C
		|=> s_axi_rresp == pfs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("no error");
	a_reset_clear: assert property (disable iff (1'b0) !aresetn
		|=> !port_f_upper_io_supply && !slave_select_input && !s_axi_bvalid)
		else $error("reset not cleared");
	a_supply_on_write: assert property ($changed(port_f_upper_io_supply)
		|-> $past(s_axi_bvalid)) else $error("supply moved without write");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
	a_read_answer: assert property (ar_ok |=> s_axi_rvalid) else $error("no read answer");
	a_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("aw ready stuck");
	a_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
endmodule // pfs_mux_props
bind pfs_mux pfs_mux_props u_pfs_mux_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.slave_select_input(slave_select_input), .port_f_upper_io_supply(port_f_upper_io_supply));
`default_nettype wire

// *** tb/tb_pfs_mux.sv ***
// Purpose: self-checking bench for pfs_mux
// Assumes: bready and rready held high
// Notes: reads checked from a queue of notes
`default_nettype none
module tb_pfs_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
	logic [95:0] pfsel; // function select bytes
	logic slave_select_input, periodic_timer_capture_in, standard_timer_capture_in;
	logic serial_data_in, serial_clock_in, serial_rx_in, port_f_upper_io_supply;
	logic [10:0] pins; // a1 a2 a3 a5 b0 b1 b2 b3 b4 e2 e3
	logic [5:0] routed; // all routed inputs
	logic [33:0] exp_q[$];
	logic [31:0] sv[4] = '{32'hFFFFFFFF, 32'h2, 32'h1, 32'h0};
	int n_mismatch, checks, seed;
	assign routed = {slave_select_input, periodic_timer_capture_in, standard_timer_capture_in,
		serial_data_in, serial_clock_in, serial_rx_in};
	pfs_mux u_pfs_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
		.port_a_bit1(pins[0]), .port_a_bit2(pins[1]), .port_a_bit3(pins[2]),
		.port_a_bit5(pins[3]), .port_b_bit0(pins[4]), .port_b_bit1(pins[5]),
		.port_b_bit2(pins[6]), .port_b_bit3(pins[7]), .port_b_bit4(pins[8]),
		.port_e_bit2(pins[9]), .port_e_bit3(pins[10]), .slave_select_input,
		.periodic_timer_capture_in, .standard_timer_capture_in, .serial_data_in,
		.serial_clock_in, .serial_rx_in, .port_f_upper_io_supply, .pin_function_sel(pfsel));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tmo(input int i);
		if (i >= 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50 && !b; i++) begin
			@(posedge aclk);
			b = s_axi_bvalid;
			bresp_seen = s_axi_bresp;
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		tmo(i + 32'(!b) * 50);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int i;
		@(posedge aclk);
		exp_q.push_back(e);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) break;
		end
		s_axi_arvalid <= 1'b0;
		tmo(i);
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1) break;
		end
		tmo(i);
	endtask
	// ----------------------------------------
	// clock, watcher and main sequence
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1) cmp("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
	end
	initial begin
		logic [10:0] p;
		logic [1:0] f;
		logic [31:0] d;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pins} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		seed = 32'h5F26;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pfs_pkg::OFF_SUPPLY, 34'h0);
		rd(pfs_pkg::OFF_ISRC1, 34'h0);
		wr(8'h38, 32'h0000000C); // pin function chosen before supply and use
		for (int i = 0; i < 4; i++) begin
			wr(pfs_pkg::OFF_SUPPLY, sv[i]);
			#1 cmp("io_supply", 34'(sv[i][1]), 34'(port_f_upper_io_supply));
			rd(pfs_pkg::OFF_SUPPLY, {2'b00, 30'h0, sv[i][1:0]});
		end
		wr(pfs_pkg::OFF_ISRC0, 32'hFFFFFFFF);
		rd(pfs_pkg::OFF_ISRC0, 34'h3F);
		for (int c = 0; c < 4; c++) begin
			f = c[1:0];
			wr(pfs_pkg::OFF_ISRC0, {26'h0, f, f, f});
			wr(pfs_pkg::OFF_ISRC1, {26'h0, f, f, f});
			repeat (3) begin
				pins <= 11'($random(seed));
				repeat (8) @(posedge aclk);
				#1 p = pins;
				cmp("routed", 34'({f[0] ? p[2] : p[1], f[0] ? p[8] : p[6], f[0] ? p[10] : p[9],
					f[0] ? p[3] : p[4], f[1] ? p[0] : p[5], f[1] ? p[0] : p[7]}), 34'(routed));
			end
		end
		d = $random(seed);
		wr(8'h38, d);
		cmp("bresp", 34'(pfs_pkg::RESP_OKAY), 34'(bresp_seen));
		#1 cmp("pfsel", 34'(d[7:0]), 34'(pfsel[95:88]));
		rd(8'h38, {26'h0, d[7:0]});
		wr(8'h3C, 32'h000000FF);
		cmp("bresp", 34'(pfs_pkg::RESP_SLVERR), 34'(bresp_seen));
		rd(8'h3C, {pfs_pkg::RESP_SLVERR, 32'h0});
		give_verdict();
	end
endmodule // tb_pfs_mux
`default_nettype wire
